// ==== rtl/fmt_pkg.sv ====
// constants and types for the converter output formatting stage
// assumes a single 100 MHz core clock domain
package fmt_pkg;
  // clock
  localparam int CORE_CLK_MHZ = 100;
  // sample path
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 16;
  // serial programming word
  localparam logic [4:0] SPI_WORD_BITS = 5'h10;
  localparam logic [4:0] SPI_HEAD_BITS = 5'h08;
  // register addresses
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FORMAT = 7'h04;
  // field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int TP_MSB = 5;
  localparam int TP_LSB = 3;
  localparam int ABP_BIT = 2;
  localparam int SCR_BIT = 1;
  localparam int SIGNED_BIT = 0;
  // reset value of the format register
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  // pattern words for output bits 15..2, and the alternate polarity mask for bits 15..0
  localparam logic [13:0] PAT_ZEROS = 14'h0000;
  localparam logic [13:0] PAT_ONES = 14'h3fff;
  localparam logic [13:0] PAT_CHECK_A = 14'h1555;
  localparam logic [13:0] PAT_CHECK_B = 14'h2aaa;
  localparam logic [15:0] ODD_BIT_MASK = 16'haaaa;

  typedef enum logic [2:0] {
    TP_OFF = 3'b000,
    TP_ZEROS = 3'b001,
    TP_ONES = 3'b011,
    TP_CHECKER = 3'b101,
    TP_TOGGLE = 3'b111
  } test_pattern_e;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_SHIFT = 2'b01,
    SER_DONE = 2'b10
  } ser_state_e;

  typedef struct packed {
    logic [1:0] unused;
    logic [2:0] test_pattern_select;
    logic alternate_polarity_enable;
    logic output_scramble_enable;
    logic signed_format_select;
  } format_s;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } sample_s;
endpackage

// ==== rtl/sample_fifo.sv ====
// first-in first-out buffer for formatted sample words
// assumes asynchronous active-low reset whose release is already synchronised cleanly
`timescale 1ns/1ps
module sample_fifo
  import fmt_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_ready = (st_reg.count != DEPTH[PW:0]);
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rd_ptr];

  // pointer and count update
  always_comb
  begin
    st_next = st_reg;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push)
    begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule

// ==== rtl/adc_output_data_formatter.sv ====
// output data formatting stage with its serial programming port
// assumes raw samples arrive in offset binary on core_clk, serial pins are asynchronous
`timescale 1ns/1ps
// Contract
// - format register lives at address 04h, bits 7 and 6 unused
// - test pattern select is register bits 5 to 3, msb in bit 5
// - select 000 passes normal conversion results
// - select 001 forces output bits 15..2 low
// - select 011 forces output bits 15..2 high
// - select 101 alternates 0101 checkerboard and its complement on bits 15..2
// - select 111 alternates all zeros and all ones on bits 15..2
// - output bits 1 and 0 are never touched by a test pattern
// - register bit 2 enables alternate bit polarity
// - register bit 1 enables output randomizer
// - bit 0 clear gives offset binary, set gives two's complement
// - alternate bit polarity forces offset binary output
// - serial word is read/write flag, 7 address bits, 8 data bits
// - software reset clears the format register to zero
module adc_output_data_formatter
  import fmt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // serial programming pins
  input wire logic ser_cs_b,
  input wire logic ser_clk,
  input wire logic ser_din,
  input wire logic ser_dout_i,
  output logic ser_dout_o,
  output logic ser_dout_oe,
  // raw conversion results
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [SAMPLE_W-1:0] sample_data,
  // formatted output words
  output logic out_valid,
  input wire logic out_ready,
  output logic [SAMPLE_W-1:0] out_data,
  // current format settings
  output logic [7:0] format_value
);
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic sdi_s1;
    logic sdi_s2;
    ser_state_e ser_state;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic [7:0] rd_byte;
    logic reading;
    logic sdo_oe;
    format_s format;
    logic alt_phase;
    logic in_rdy;
    sample_s stage;
    sample_s outq;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [SAMPLE_W-1:0] fifo_out_data;
  logic fifo_take;

  // shape one raw sample by the current format settings
  function automatic logic [SAMPLE_W-1:0] shape_word(
    input logic [SAMPLE_W-1:0] raw,
    input format_s f,
    input logic phase
  );
    logic [SAMPLE_W-1:0] w;
    w = raw;
    // two's complement only when polarity mode is off
    if (f.signed_format_select && !f.alternate_polarity_enable)
    begin
      w[SAMPLE_W-1] = ~w[SAMPLE_W-1];
    end
    if (f.output_scramble_enable)
    begin
      w[SAMPLE_W-1:1] = w[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){w[0]}};
    end
    if (f.alternate_polarity_enable)
    begin
      w = w ^ ODD_BIT_MASK;
    end
    // patterns override bits 15..2 only, low two bits keep their path
    case (f.test_pattern_select)
      TP_OFF:
      begin
        w = w;
      end
      TP_ZEROS:
      begin
        w[SAMPLE_W-1:2] = PAT_ZEROS;
      end
      TP_ONES:
      begin
        w[SAMPLE_W-1:2] = PAT_ONES;
      end
      TP_CHECKER:
      begin
        w[SAMPLE_W-1:2] = phase ? PAT_CHECK_B : PAT_CHECK_A;
      end
      TP_TOGGLE:
      begin
        w[SAMPLE_W-1:2] = phase ? PAT_ONES : PAT_ZEROS;
      end
      default:
      begin
        w = w; // unused codes pass data through
      end
    endcase
    return w;
  endfunction

  // readback value of an addressed register
  function automatic logic [7:0] read_value(input logic [6:0] addr, input format_s f);
    logic [7:0] v;
    v = 8'h00;
    if (addr == ADDR_FORMAT)
    begin
      v = {2'b00, f[TP_MSB:0]};
    end
    return v;
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync_reg <= 2'b00;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // serial engine and sample stage
  always_comb
  begin
    logic sck_rise;
    logic sck_fall;
    logic [6:0] head_addr;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    head_addr = 7'h00;
    st_next = st_reg;
    // pin synchronisers
    st_next.cs_s1 = ser_cs_b;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.sck_s1 = ser_clk;
    st_next.sck_s2 = st_reg.sck_s1;
    st_next.sck_d = st_reg.sck_s2;
    st_next.sdi_s1 = ser_din;
    st_next.sdi_s2 = st_reg.sdi_s1;
    sck_rise = st_reg.sck_s2 && !st_reg.sck_d;
    sck_fall = !st_reg.sck_s2 && st_reg.sck_d;
    head_addr = {st_reg.shift[5:0], st_reg.sdi_s2};

    // frame sequencing
    case (st_reg.ser_state)
      SER_IDLE:
      begin
        st_next.bit_cnt = 5'h00;
        st_next.reading = 1'b0;
        st_next.sdo_oe = 1'b0;
        if (!st_reg.cs_s2)
        begin
          st_next.ser_state = SER_SHIFT;
        end
      end
      SER_SHIFT:
      begin
        if (st_reg.cs_s2)
        begin
          st_next.ser_state = SER_DONE;
        end
        else
        begin
          // first 16 rising edges shift, later ones ignored
          if (sck_rise && (st_reg.bit_cnt < SPI_WORD_BITS))
          begin
            st_next.shift = {st_reg.shift[14:0], st_reg.sdi_s2};
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == (SPI_HEAD_BITS - 5'h01))
            begin
              st_next.reading = st_reg.shift[6];
              st_next.rd_byte = read_value(head_addr, st_reg.format);
            end
          end
          // readback bits leave on falling edges, pulling low for zero
          if (sck_fall && st_reg.reading && (st_reg.bit_cnt >= SPI_HEAD_BITS)
              && (st_reg.bit_cnt < SPI_WORD_BITS))
          begin
            st_next.sdo_oe = ~st_reg.rd_byte[7];
            st_next.rd_byte = {st_reg.rd_byte[6:0], 1'b0};
          end
        end
      end
      SER_DONE:
      begin
        st_next.sdo_oe = 1'b0;
        st_next.ser_state = SER_IDLE;
        // only a complete write frame commits
        if ((st_reg.bit_cnt == SPI_WORD_BITS) && !st_reg.shift[15])
        begin
          if (st_reg.shift[14:8] == ADDR_FORMAT)
          begin
            st_next.format = format_s'({2'b00, st_reg.shift[TP_MSB:0]});
          end
          else if ((st_reg.shift[14:8] == ADDR_RESET) && st_reg.shift[SOFT_RESET_BIT])
          begin
            st_next.format = format_s'(FORMAT_RESET);
            st_next.alt_phase = 1'b0;
          end
        end
      end
      default:
      begin
        st_next.ser_state = SER_IDLE;
      end
    endcase

    // one-word stage in front of the fifo
    if (st_reg.stage.valid && fifo_in_ready)
    begin
      st_next.stage.valid = 1'b0;
    end
    if (sample_valid && st_reg.in_rdy)
    begin
      st_next.stage.valid = 1'b1;
      st_next.stage.data = shape_word(sample_data, st_reg.format, st_reg.alt_phase);
      // alternating patterns flip phase on each output word
      if (st_reg.format.test_pattern_select[TP_LSB-3] && st_reg.format.test_pattern_select[2])
      begin
        st_next.alt_phase = ~st_reg.alt_phase;
      end
    end
    st_next.in_rdy = ~st_next.stage.valid;

    // output register so the capture side sees flops, refilled from the fifo head
    if (fifo_take)
    begin
      st_next.outq.valid = fifo_out_valid;
      st_next.outq.data = fifo_out_data;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.cs_s1 <= 1'b1;
      st_reg.cs_s2 <= 1'b1;
      st_reg.ser_state <= SER_IDLE;
      st_reg.format <= format_s'(FORMAT_RESET);
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // buffer between stage and capture side
  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(st_reg.stage.valid),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.stage.data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out_data)
  );

  // outputs
  assign sample_ready = st_reg.in_rdy;
  // head word moves on when the output register is empty or being taken
  assign fifo_take = !st_reg.outq.valid || out_ready;
  assign out_valid = st_reg.outq.valid;
  assign out_data = st_reg.outq.data;
  assign ser_dout_o = 1'b0; // open drain only pulls low
  assign ser_dout_oe = st_reg.sdo_oe;
  assign format_value = {2'b00, st_reg.format[TP_MSB:0]};
endmodule

// ==== bench/fmt_checker.sv ====
// port checker for the formatting stage
// assumes a bind onto the top module
`timescale 1ns/1ps
module fmt_checker
  import fmt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ser_cs_b,
  input wire logic ser_dout_o,
  input wire logic ser_dout_oe,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [SAMPLE_W-1:0] out_data,
  input wire logic [7:0] format_value
);
  logic [7:0] prev_reg;
  logic [1:0] calm_reg;
  logic calm;
  logic [2:0] tp;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // cycles since the format last moved
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      prev_reg <= 8'h00;
      calm_reg <= 2'h0;
    end
    else
    begin
      prev_reg <= format_value;
      calm_reg <= (format_value != prev_reg) ? 2'h0 : calm_reg + {1'b0, calm_reg != 2'h3};
    end
  assign calm = calm_reg == 2'h3;
  assign tp = format_value[5:3];
  unused_bits_zero_a: assert property (format_value[7:6] == 2'b00)
    else $error("unused format bits set");
  zeros_pattern_a: assert property (calm && tp == 3'b001 && out_valid |->
    out_data[15:2] == 14'h0000) else $error("zeros pattern wrong");
  ones_pattern_a: assert property (calm && tp == 3'b011 && out_valid |->
    out_data[15:2] == 14'h3fff) else $error("ones pattern wrong");
  checker_words_a: assert property (calm && tp == 3'b101 && out_valid |->
    out_data[15:2] inside {14'h1555, 14'h2aaa}) else $error("checkerboard wrong");
  toggle_words_a: assert property (calm && tp == 3'b111 && out_valid |->
    out_data[15:2] inside {14'h0000, 14'h3fff}) else $error("toggle pattern wrong");
  drain_only_a: assert property (ser_dout_o == 1'b0)
    else $error("serial out driven high");
  line_release_a: assert property ($rose(ser_cs_b) |-> ##[0:6] !ser_dout_oe)
    else $error("serial out held after frame");
  take_gap_a: assert property (sample_valid && sample_ready |=> !sample_ready)
    else $error("ready not dropped after take");
  head_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("head word moved while stalled");
  cover property (out_valid && !out_ready);
  cover property (tp == 3'b111 && out_valid && out_ready);
  cover property (ser_dout_oe);
endmodule

bind adc_output_data_formatter fmt_checker chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .ser_cs_b(ser_cs_b), .ser_dout_o(ser_dout_o), .ser_dout_oe(ser_dout_oe),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data), .format_value(format_value));

// ==== bench/capture_model.sv ====
// capture side model taking formatted words
// assumes the bench seeds the random source
`timescale 1ns/1ps
module capture_model
(
  // clock
  input wire logic clk,
  // control
  input wire logic stall,
  // stream
  output logic out_ready
);
  // ready moves at the falling edge, withheld at random
  initial
  begin
    out_ready = 1'b0;
    forever
    begin
      @(negedge clk);
      out_ready <= !stall && ($urandom % 4 != 0);
    end
  end
endmodule

// ==== bench/adc_output_data_formatter_tb_top.sv ====
// self-checking bench for the formatting stage
// assumes checker bound and capture model beside the design
`timescale 1ns/1ps
module adc_output_data_formatter_tb_top
  import fmt_pkg::*;
;
  logic core_clk = 1'b0, rst_b = 1'b0, cs_b = 1'b1, sck = 1'b0, sdi = 1'b0;
  logic s_valid = 1'b0, stall = 1'b1, oe, s_ready, o_valid, o_ready;
  logic [15:0] s_data = 16'h0000, o_data;
  logic [7:0] fmt, rd;
  logic [7:0] fmts[11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h18,
    8'h28, 8'h38, 8'hff};
  int err_total = 0, num_checks = 0, ph = 0, cnt;
  logic [15:0] expq[$];
  initial forever #5 core_clk = ~core_clk;
  adc_output_data_formatter dut_u (.core_clk(core_clk), .rst_b(rst_b), .ser_cs_b(cs_b),
    .ser_clk(sck), .ser_din(sdi), .ser_dout_i(~oe), .ser_dout_o(), .ser_dout_oe(oe),
    .sample_valid(s_valid), .sample_ready(s_ready), .sample_data(s_data),
    .out_valid(o_valid), .out_ready(o_ready), .out_data(o_data), .format_value(fmt));
  capture_model cap_u (.clk(core_clk), .stall(stall), .out_ready(o_ready));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int lim);
    @(negedge core_clk);
    if (++cnt > lim)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // expected word from raw sample and format
  function automatic logic [15:0] model(input logic [15:0] r, input logic [7:0] f);
    logic [15:0] d;
    d = r;
    if (f[0] && !f[2]) d[15] = ~d[15];
    if (f[1]) d[15:1] = d[15:1] ^ {15{d[0]}};
    if (f[2]) d = d ^ 16'haaaa;
    case (f[5:3])
      3'b001: d[15:2] = 14'h0000;
      3'b011: d[15:2] = 14'h3fff;
      3'b101: d[15:2] = ph[0] ? 14'h2aaa : 14'h1555;
      3'b111: d[15:2] = ph[0] ? 14'h3fff : 14'h0000;
      default: ;
    endcase
    if (f[5:3] inside {3'b101, 3'b111}) ph++;
    return d;
  endfunction
  // one 16-bit serial frame, msb first, readback sampled before each of the last 8 rises
  task automatic frame(input logic [15:0] w);
    cs_b = 1'b0;
    repeat (6) @(negedge core_clk);
    for (int i = 15; i >= 0; i--)
    begin
      sdi = w[i];
      repeat (6) @(negedge core_clk);
      if (i < 8) rd = {rd[6:0], ~oe};
      sck = 1'b1;
      repeat (6) @(negedge core_clk);
      sck = 1'b0;
    end
    cs_b = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
  // offer n random samples, holding each until taken
  task automatic send(input int n, input logic [7:0] f);
    for (int k = 0; k < n; k++)
    begin
      s_valid = 1'b1;
      s_data = 16'($urandom);
      cnt = 0;
      while (s_ready !== 1'b1) tick(200);
      expq.push_back(model(s_data, f));
      @(negedge core_clk);
    end
    s_valid = 1'b0;
  endtask
  task automatic drain;
    stall = 1'b0;
    cnt = 0;
    while (expq.size() != 0 || o_valid !== 1'b0) tick(600);
  endtask
  // compare every taken word with the model
  always @(posedge core_clk)
    if (o_valid === 1'b1 && o_ready === 1'b1)
      check(o_data, expq.size() ? expq.pop_front() : 16'hxxxx);
  initial
  begin
    void'($urandom(44461));
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    check({8'h00, fmt}, 16'h0000);
    check({15'h0000, o_valid}, 16'h0000);
    frame({1'b1, ADDR_FORMAT, 8'hff});
    check({8'h00, rd}, 16'h0000);
    check({8'h00, fmt}, 16'h0000);
    // stage, fifo and output register all fill before ready stays low
    send(18, 8'h00);
    repeat (4) @(negedge core_clk);
    check({15'h0000, s_ready}, 16'h0000);
    drain();
    foreach (fmts[j])
    begin
      frame({1'b0, ADDR_FORMAT, fmts[j]});
      check({8'h00, fmt}, {8'h00, fmts[j] & 8'h3f});
      frame({1'b1, ADDR_FORMAT, 8'h00});
      check({8'h00, rd}, {8'h00, fmts[j] & 8'h3f});
      send(12, fmt);
      drain();
    end
    frame({1'b0, 7'h05, 8'h00});
    check({8'h00, fmt}, 16'h003f);
    // leave the alternating phase odd so the soft reset must clear it
    send(1, fmt);
    drain();
    frame({1'b0, ADDR_RESET, 8'h80});
    check({8'h00, fmt}, 16'h0000);
    ph = 0;
    frame({1'b0, ADDR_FORMAT, 8'h28});
    send(5, 8'h28);
    drain();
    tally_and_finish();
  end
endmodule
